// ===== prf_top.sv
// Peripheral request flag register with masked interrupt output.
// Assumes timer, capture and serial events are synchronous to CLK_SYS.
`timescale 1ns/10ps
module prf_top #(
    parameter int PORT_WIDTH = 4
) (
    input  wire logic                  CLK_SYS,
    input  wire logic                  RSTN,
    input  wire logic [1:0]            BANK,
    input  wire logic [7:0]            ADDR,
    input  wire logic [7:0]            WDATA,
    input  wire logic                  WR,
    input  wire logic                  RD,
    output logic      [7:0]            RDATA,
    output logic                       IRQ,
    input  wire logic [PORT_WIDTH-1:0] PORT_IN,
    input  wire logic                  CAPTURE_SELECT,
    input  wire logic                  TMR1_ROLLOVER,
    input  wire logic                  TMR2_ROLLOVER,
    input  wire logic                  THIRD_TIMER_PERIOD_ROLLOVER,
    input  wire logic                  THIRD_TIMER_OVERFLOW,
    input  wire logic                  CAPTURE1_EVENT,
    input  wire logic                  CAPTURE2_EVENT,
    input  wire logic                  TX_BUFFER_EMPTY,
    input  wire logic                  RX_BUFFER_FULL
);
    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    generate
        if (PORT_WIDTH < 1 || PORT_WIDTH > 8) begin : g_bad_width
            $error("PORT_WIDTH must be 1 to 8");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic flags_sel;
    logic status_sel;
    logic mask_sel;
    logic port_sel;
    logic flags_wr;
    assign flags_sel  = (BANK == prf_pkg::PRF_FLAGS_BANK) &&
                        (ADDR == prf_pkg::PRF_FLAGS_ADDR);
    assign status_sel = (BANK == prf_pkg::PRF_OWN_BANK) &&
                        (ADDR == prf_pkg::PRF_STATUS_ADDR);
    assign mask_sel   = (BANK == prf_pkg::PRF_OWN_BANK) &&
                        (ADDR == prf_pkg::PRF_MASK_ADDR);
    assign port_sel   = (BANK == prf_pkg::PRF_OWN_BANK) &&
                        (ADDR == prf_pkg::PRF_PORT_ADDR);
    assign flags_wr   = WR && flags_sel;

    // ------------------------------------------------------------------
    // Strobes per register
    // ------------------------------------------------------------------
    logic status_wr;
    logic mask_wr;
    logic flags_rd;
    logic status_rd;
    logic mask_rd;
    logic port_rd;
    assign status_wr = WR && status_sel;
    assign mask_wr   = WR && mask_sel;
    assign flags_rd  = RD && flags_sel;
    assign status_rd = RD && status_sel;
    assign mask_rd   = RD && mask_sel;
    assign port_rd   = RD && port_sel;

    // ------------------------------------------------------------------
    // Port change detect
    // ------------------------------------------------------------------
    logic [PORT_WIDTH-1:0] port_latch;
    logic                  port_mismatch;
    assign port_mismatch = |(PORT_IN ^ port_latch);

    // Reading the port relatches it and ends the mismatch
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            port_latch <= '0;
        end else if (port_rd) begin
            port_latch <= PORT_IN;
        end
    end

    // ------------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------------
    logic       third_timer_event;
    logic [7:0] set_vec;
    logic [7:0] flags;
    logic [7:2] soft_flags;

    // Third timer source by capture select
    always_comb begin
        if (CAPTURE_SELECT) begin
            third_timer_event = THIRD_TIMER_OVERFLOW;
        end else begin
            third_timer_event = THIRD_TIMER_PERIOD_ROLLOVER;
        end
    end

    always_comb begin
        set_vec = 8'h00;
        set_vec[prf_pkg::PRF_BIT_PORT] = port_mismatch;
        set_vec[prf_pkg::PRF_BIT_THIRD_TIMER] = third_timer_event;
        set_vec[prf_pkg::PRF_BIT_TMR2] = TMR2_ROLLOVER;
        set_vec[prf_pkg::PRF_BIT_TMR1] = TMR1_ROLLOVER;
        set_vec[prf_pkg::PRF_BIT_CAP2] = CAPTURE2_EVENT;
        set_vec[prf_pkg::PRF_BIT_CAP1] = CAPTURE1_EVENT;
    end

    // ------------------------------------------------------------------
    // Software flags, writes of zero clear
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 2; i < 8; i++) begin : g_flag
            prf_event_latch u_latch (
                .clk   (CLK_SYS),
                .rst_n (RSTN),
                .set   (set_vec[i]),
                .clr   (flags_wr && !WDATA[i]),
                .flag  (soft_flags[i])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Hardware-driven serial flags
    // ------------------------------------------------------------------
    logic serial_transmit_flag;
    logic serial_receive_flag;

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            serial_transmit_flag <=
                prf_pkg::PRF_FLAGS_RESET[prf_pkg::PRF_BIT_TX];
        end else begin
            serial_transmit_flag <= TX_BUFFER_EMPTY;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            serial_receive_flag <=
                prf_pkg::PRF_FLAGS_RESET[prf_pkg::PRF_BIT_RX];
        end else begin
            serial_receive_flag <= RX_BUFFER_FULL;
        end
    end

    // ------------------------------------------------------------------
    // Flag register image
    // ------------------------------------------------------------------
    always_comb begin
        flags = {soft_flags, 2'h0};
        flags[prf_pkg::PRF_BIT_TX] = serial_transmit_flag;
        flags[prf_pkg::PRF_BIT_RX] = serial_receive_flag;
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    logic [7:0] status;
    logic [7:0] mask;
    logic [7:0] ev_set;
    logic [7:0] status_clr;
    assign ev_set     = set_vec | {6'h00, TX_BUFFER_EMPTY, RX_BUFFER_FULL};
    assign status_clr = status_wr ? WDATA : 8'h00;

    // Write one clears, a coinciding event wins
    generate
        for (i = 0; i < 8; i++) begin : g_status
            prf_event_latch u_status (
                .clk   (CLK_SYS),
                .rst_n (RSTN),
                .set   (ev_set[i]),
                .clr   (status_clr[i]),
                .flag  (status[i])
            );
        end
    endgenerate

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            mask <= prf_pkg::PRF_MASK_RESET;
        end else if (mask_wr) begin
            mask <= WDATA;
        end
    end

    // ------------------------------------------------------------------
    // Pending interrupts
    // ------------------------------------------------------------------
    logic [7:0] pending;
    assign pending = status & mask;

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |pending;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        if (flags_rd) begin
            next_rdata = flags;
        end else if (status_rd) begin
            next_rdata = status;
        end else if (mask_rd) begin
            next_rdata = mask;
        end else if (port_rd) begin
            next_rdata = 8'(PORT_IN);
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= next_rdata;
        end
    end
endmodule

// ===== prf_pkg.sv
// Constants for the peripheral request flag register block.
// Assumes one core clock and a plain register port of eight data bits.
package prf_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] PRF_FLAGS_ADDR  = 8'h16;
    localparam logic [1:0] PRF_FLAGS_BANK  = 2'h1;
    localparam logic [7:0] PRF_STATUS_ADDR = 8'h20;
    localparam logic [7:0] PRF_MASK_ADDR   = 8'h21;
    localparam logic [7:0] PRF_PORT_ADDR   = 8'h22;
    localparam logic [1:0] PRF_OWN_BANK    = 2'h3;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PRF_BIT_PORT  = 7;
    localparam int PRF_BIT_THIRD_TIMER  = 6;
    localparam int PRF_BIT_TMR2  = 5;
    localparam int PRF_BIT_TMR1  = 4;
    localparam int PRF_BIT_CAP2  = 3;
    localparam int PRF_BIT_CAP1  = 2;
    localparam int PRF_BIT_TX    = 1;
    localparam int PRF_BIT_RX    = 0;
    // ------------------------------------------------------------------
    // Reset values and software flag mask
    // ------------------------------------------------------------------
    localparam logic [7:0] PRF_FLAGS_RESET = 8'h02;
    localparam logic [7:0] PRF_MASK_RESET  = 8'h00;
    localparam logic [7:0] PRF_SOFT_MASK   = 8'hFC;
endpackage

// ===== prf_event_latch.sv
// Sticky event latch for one software-clearable flag bit.
// Assumes set and clear are synchronous one-cycle terms.
`timescale 1ns/10ps
module prf_event_latch (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic set,
    input  wire logic clr,
    output logic      flag
);
    // ------------------------------------------------------------------
    // Set wins over clear
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= 1'b0;
        end else if (set) begin
            flag <= 1'b1;
        end else if (clr) begin
            flag <= 1'b0;
        end
    end
endmodule

// ===== prf_top_asserts.sv
// Checker for the peripheral request flag block.
// Assumes it is bound to prf_top and sees only its ports.
`timescale 1ns/10ps
module prf_top_asserts (
    input wire logic       CLK_SYS,
    input wire logic       RSTN,
    input wire logic [1:0] BANK,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       IRQ,
    input wire logic       CAPTURE_SELECT,
    input wire logic       TMR1_ROLLOVER,
    input wire logic       TMR2_ROLLOVER,
    input wire logic       THIRD_TIMER_PERIOD_ROLLOVER,
    input wire logic       THIRD_TIMER_OVERFLOW,
    input wire logic       CAPTURE1_EVENT,
    input wire logic       TX_BUFFER_EMPTY,
    input wire logic       RX_BUFFER_FULL
);
    // --------------------------------------------------------------
    // Properties
    // --------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    sequence s_flag_rd;
        RD && BANK == 2'h1 && ADDR == 8'h16;
    endsequence
    property p_sets(ev, int b);
        ev ##1 !WR ##1 s_flag_rd |=> RDATA[b];
    endproperty
    a_rdata_idle: assert property (!RD |=> RDATA == 8'h00)
        else $error("read data not idle");
    a_unmapped_zero: assert property (RD && !(BANK == 2'h1 && ADDR == 8'h16)
        && !(BANK == 2'h3 && ADDR inside {8'h20, 8'h21, 8'h22})
        |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_serial_levels: assert property ($past(RSTN)
        && RD && BANK == 2'h1 && ADDR == 8'h16
        && $stable(TX_BUFFER_EMPTY) && $stable(RX_BUFFER_FULL)
        |=> RDATA[1] == $past(TX_BUFFER_EMPTY)
        && RDATA[0] == $past(RX_BUFFER_FULL))
        else $error("serial flags wrong");
    a_mask_quiets_irq: assert property (WR && BANK == 2'h3
        && ADDR == 8'h21 && WDATA == 8'h00 |=> ##1 !IRQ)
        else $error("masked interrupt high");
    a_tmr1_sets: assert property (p_sets(TMR1_ROLLOVER, 4))
        else $error("first timer flag not set");
    a_tmr2_sets: assert property (p_sets(TMR2_ROLLOVER, 5))
        else $error("second timer flag not set");
    a_capture_sets: assert property (p_sets(CAPTURE1_EVENT, 2))
        else $error("capture flag not set");
    a_period_sets: assert property (p_sets(THIRD_TIMER_PERIOD_ROLLOVER
        && !CAPTURE_SELECT, 6))
        else $error("period flag not set");
    a_overflow_sets: assert property (p_sets(THIRD_TIMER_OVERFLOW
        && CAPTURE_SELECT, 6))
        else $error("overflow flag not set");
endmodule
bind prf_top prf_top_asserts i_prf_top_asserts (.CLK_SYS, .RSTN, .BANK,
    .ADDR, .WDATA, .WR, .RD, .RDATA, .IRQ, .CAPTURE_SELECT, .TMR1_ROLLOVER,
    .TMR2_ROLLOVER, .THIRD_TIMER_PERIOD_ROLLOVER, .THIRD_TIMER_OVERFLOW, .CAPTURE1_EVENT,
    .TX_BUFFER_EMPTY, .RX_BUFFER_FULL);

// ===== tb_top.sv
// Testbench for the peripheral request flag block.
// Assumes prf_top and its checker are compiled before this file.
`timescale 1ns/10ps
module tb_top;
    logic [7:0]  a, wd, rdata, d;
    logic [1:0]  bk;
    logic        clk, rstn, wr, rd, irq, sel, tx, rx;
    logic [3:0]  port;
    logic [5:0]  ev;
    int          err_total, n_compared;
    logic [14:0] tbl [8] = '{15'h0212, 15'h0422, 15'h0842, 15'h0902,
                             15'h1142, 15'h1002, 15'h2006, 15'h400A};
    prf_top i_prf_top (.CLK_SYS(clk), .RSTN(rstn), .BANK(bk), .ADDR(a),
        .WDATA(wd), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq),
        .PORT_IN(port), .CAPTURE_SELECT(sel), .TMR1_ROLLOVER(ev[0]),
        .TMR2_ROLLOVER(ev[1]), .THIRD_TIMER_PERIOD_ROLLOVER(ev[2]),
        .THIRD_TIMER_OVERFLOW(ev[3]), .CAPTURE1_EVENT(ev[4]),
        .CAPTURE2_EVENT(ev[5]), .TX_BUFFER_EMPTY(tx), .RX_BUFFER_FULL(rx));
    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic reg_wr(input logic [1:0] b, input logic [7:0] x, v);
        @(posedge clk);
        {bk, a, wd, wr} <= {b, x, v, 1'b1};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [1:0] b, input logic [7:0] x);
        @(posedge clk);
        {bk, a, rd} <= {b, x, 1'b1};
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic pulse(input logic [5:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 6'h00;
    endtask
    task automatic chk(input logic [7:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic irq_is(input logic v);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk({7'h00, irq}, {7'h00, v});
    endtask
    task automatic test_done;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // --------------------------------------------------------------
    // Stimulus
    // --------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #1000000;
        err_total++;
        test_done();
    end
    initial begin
        {a, wd, bk, wr, rd, sel, ev, port, rx, rstn} = '0;
        tx = 1'b1;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        reg_rd(2'h1, 8'h16);
        chk(d, 8'h02);
        reg_rd(2'h0, 8'h16);
        chk(d, 8'h00);
        reg_rd(2'h1, 8'h17);
        chk(d, 8'h00);
        @(posedge clk);
        {tx, rx} <= 2'b01;
        reg_wr(2'h1, 8'h16, 8'hFF);
        reg_rd(2'h1, 8'h16);
        chk(d, 8'h01);
        @(posedge clk);
        {tx, rx} <= 2'b10;
        for (int i = 0; i < 8; i++) begin
            reg_wr(2'h1, 8'h16, 8'h00);
            @(posedge clk);
            sel <= tbl[i][8];
            pulse(tbl[i][14:9]);
            reg_rd(2'h1, 8'h16);
            chk(d, tbl[i][7:0]);
        end
        reg_wr(2'h1, 8'h16, 8'h00);
        @(posedge clk);
        port <= 4'hA;
        reg_wr(2'h1, 8'h16, 8'h00);
        reg_rd(2'h1, 8'h16);
        chk(d, 8'h82);
        reg_rd(2'h3, 8'h22);
        chk(d, 8'h0A);
        reg_wr(2'h1, 8'h16, 8'h00);
        reg_rd(2'h1, 8'h16);
        chk(d, 8'h02);
        reg_wr(2'h3, 8'h20, 8'hFF);
        reg_wr(2'h3, 8'h21, 8'h04);
        reg_rd(2'h3, 8'h21);
        chk(d, 8'h04);
        irq_is(1'b0);
        pulse(6'h10);
        irq_is(1'b1);
        reg_rd(2'h3, 8'h20);
        chk(d, 8'h06);
        reg_wr(2'h3, 8'h21, 8'h00);
        irq_is(1'b0);
        reg_wr(2'h3, 8'h21, 8'h04);
        irq_is(1'b1);
        reg_wr(2'h3, 8'h20, 8'h04);
        irq_is(1'b0);
        reg_rd(2'h3, 8'h20);
        chk(d, 8'h02);
        test_done();
    end
endmodule
